// [pkg/cia_defs.svh]
// constants for the interrupt acknowledge block and its requester
// assumes inclusion by bare name from package and modules
`ifndef CIA_DEFS_SVH
`define CIA_DEFS_SVH
`define CIA_LVL_W        4
`define CIA_MASK_W       4
`define CIA_ADDR_W       32
`define CIA_NONE_CODE    4'hf
`define CIA_LVL_LSB      2
`define CIA_OPT_BIT      6
`define CIA_AV_BIT0      1'h1
`define CIA_NMI_BIT0     1'h0
`define CIA_NMI_VECTOR   8'h00
`define CIA_STATUS_IACK  4'h0
`define CIA_STATUS_AVACK 4'h1
`define CIA_SIZE_BYTE    2'h1
// autovector and nonmaskable acknowledges run a fixed number of states
`define CIA_FIXED_STATES 3'h3
// idle cycles after an acknowledge so that level samples taken before the withdrawal are not taken again
`define CIA_HOLDOFF      3'h2
`endif

// [pkg/cia_pkg.sv]
// types shared by the acknowledge block and the bench
// assumes cia_defs.svh is on the include path
`include "cia_defs.svh"
package cia_pkg;
	typedef enum logic [1:0] {
		cia_ack_none,
		cia_ack_full,
		cia_ack_auto,
		cia_ack_nmi
	} cia_ack_type;
endpackage

// [pkg/cia_if.sv]
// link between the processor acknowledge logic and the interrupting party
// assumes one shared clock; pins are plain logic, no two-way pins
`timescale 1ns/1ps
`include "cia_defs.svh"
interface cia_if;
	logic [`CIA_LVL_W-1:0]  level_request_inputs;
	logic                   request_option_input_n;
	logic                   self_vector_request_n;
	logic                   nonmaskable_request_n;
	logic [`CIA_ADDR_W-1:0] ack_addr;
	logic                   addr_valid;
	logic [3:0]             access_status_code;
	logic [1:0]             transfer_size;
	logic                   ack_strobe;
	logic [7:0]             vector_data;
	logic                   async_transfer_ack_n;
	logic                   fault_n;
	logic                   retry_n;
	logic                   data_latched_out_n;

	modport device (
		input  level_request_inputs, request_option_input_n, self_vector_request_n,
		       nonmaskable_request_n, vector_data, async_transfer_ack_n, fault_n, retry_n,
		output ack_addr, addr_valid, access_status_code, transfer_size, ack_strobe,
		       data_latched_out_n
	);
	modport requester (
		output level_request_inputs, request_option_input_n, self_vector_request_n,
		       nonmaskable_request_n, vector_data, async_transfer_ack_n, fault_n, retry_n,
		input  ack_addr, addr_valid, access_status_code, transfer_size, ack_strobe,
		       data_latched_out_n
	);
endinterface

// [core/cia_device.sv]
// processor side interrupt intake and acknowledge sequencer
// assumes the link interface on one side, the processor sequencer on the other
// What this block and its requester do
// R01 - fifteen maskable levels plus nonmaskable request
// R02 - wait for instruction end unless abortable
// R03 - take inverted level only above mask
// R04 - nonmaskable request always taken
// R05 - inverted level on address 2..5, option 6
// R06 - option only passes into address, vector
// R07 - full acknowledge reads vector from data 0..7
// R08 - full acknowledge: byte read, acknowledge status
// R09 - requester returns vector and transfer acknowledge
// R10 - fault and retry honoured in full acknowledge
// R11 - requester withdraws level after acknowledge
// R12 - code zero highest, all ones means none
// R13 - autovector: vector is option and level
// R14 - autovector: no waits, no ready, no exceptions
// R15 - requester releases level and autovector
// R16 - level sampled twice, autovector once
// R17 - autovector valid at second level sample
// R18 - nonmaskable: vector zero, address all zero
// R19 - nonmaskable: no waits, acks or exceptions
// R20 - autovector status; address bit zero distinguishes
// R21 - requester negates nonmaskable after acknowledge
// R22 - nonmaskable uses level zero offset
// R23 - mask in, vector and type out
`timescale 1ns/1ps
`include "cia_defs.svh"
module cia_device (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	cia_if.device                       link,
	input  wire logic [`CIA_MASK_W-1:0] priority_mask_field,
	input  wire logic                   instr_boundary,
	input  wire logic                   instr_abortable,
	output logic                        intr_pending,
	output logic                        abort_instr,
	output logic                        ack_done,
	output logic                        ack_faulted,
	output logic [7:0]                  vector_out,
	output cia_pkg::cia_ack_type        ack_kind
);
	typedef enum logic [2:0] {
		cia_st_idle,
		cia_st_full,
		cia_st_fixed,
		cia_st_retry
	} cia_state_type;

	////////////////////////////////////////////////////////////////
	// input sampling
	logic [3:0] lvl_s1_reg, lvl_s1_next, lvl_s2_reg, lvl_s2_next;
	logic       opt_reg, opt_next, nmi_reg, nmi_next;
	logic [3:0] inv_lvl;
	logic       lvl_stable, lvl_take, nmi_take, any_take;

	always_comb begin
		lvl_s1_next = link.level_request_inputs;
		lvl_s2_next = lvl_s1_reg;
		opt_next    = link.request_option_input_n;
		nmi_next    = ~link.nonmaskable_request_n;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lvl_s1_reg <= `CIA_NONE_CODE;
			lvl_s2_reg <= `CIA_NONE_CODE;
			opt_reg    <= 1'h1;
			nmi_reg    <= 1'h0;
		end else if (clk_en) begin
			lvl_s1_reg <= lvl_s1_next; // R16
			lvl_s2_reg <= lvl_s2_next; // R16
			opt_reg    <= opt_next;
			nmi_reg    <= nmi_next;
		end
	end

	assign inv_lvl    = ~lvl_s2_reg; // R03
	assign lvl_stable = (lvl_s1_reg == lvl_s2_reg) && (lvl_s2_reg != `CIA_NONE_CODE); // R16 R12 R01
	assign lvl_take   = lvl_stable && (inv_lvl > priority_mask_field); // R03
	assign nmi_take   = nmi_reg; // R04
	assign any_take   = lvl_take || nmi_take;

	////////////////////////////////////////////////////////////////
	// acknowledge sequencer
	cia_state_type              st_reg, st_next;
	logic [2:0]                 cnt_reg, cnt_next;
	logic [`CIA_ADDR_W-1:0]     addr_reg, addr_next;
	logic                       av_reg, av_next, strobe_reg, strobe_next;
	logic [3:0]                 sas_reg, sas_next;
	logic [1:0]                 size_reg, size_next;
	logic                       data_latched_out_n_reg, data_latched_out_n_next, done_reg, done_next, flt_reg, flt_next;
	logic                       pend_reg, pend_next, abort_reg, abort_next;
	logic [7:0]                 vec_reg, vec_next;
	cia_pkg::cia_ack_type       kind_reg, kind_next;

	always_comb begin
		st_next     = st_reg;
		cnt_next    = cnt_reg;
		addr_next   = addr_reg;
		av_next     = av_reg;
		strobe_next = strobe_reg;
		sas_next    = sas_reg;
		size_next   = size_reg;
		data_latched_out_n_next = 1'h1;
		done_next   = 1'h0;
		flt_next    = 1'h0;
		vec_next    = vec_reg;
		kind_next   = kind_reg;
		pend_next   = any_take;
		abort_next  = any_take && instr_abortable; // R02
		case (st_reg)
			cia_st_idle: begin
				if (cnt_reg != 3'h0) begin
					// after a full acknowledge lvl_s2_reg still holds the request just served
					cnt_next = cnt_reg - 3'h1;
				end else if (any_take && (instr_boundary || instr_abortable)) begin // R02
					strobe_next = 1'h1;
					av_next     = 1'h1;
					if (nmi_take) begin
						addr_next = '0; // R18
						sas_next  = `CIA_STATUS_AVACK; // R20
						vec_next  = `CIA_NMI_VECTOR; // R18 R22
						kind_next = cia_pkg::cia_ack_nmi;
						cnt_next  = `CIA_FIXED_STATES; // R19
						st_next   = cia_st_fixed;
					end else begin
						addr_next = '0;
						addr_next[`CIA_LVL_LSB +: 4] = inv_lvl; // R05
						addr_next[`CIA_OPT_BIT]      = ~opt_reg; // R05 R06
						if (!link.self_vector_request_n) begin // R13 R16 R17
							addr_next[1:0] = {1'h1, `CIA_AV_BIT0}; // R20
							sas_next  = `CIA_STATUS_AVACK; // R20
							vec_next  = {3'h0, ~opt_reg, lvl_s2_reg}; // R13
							kind_next = cia_pkg::cia_ack_auto;
							cnt_next  = `CIA_FIXED_STATES; // R14
							st_next   = cia_st_fixed;
						end else begin
							addr_next[1:0] = 2'h3;
							sas_next  = `CIA_STATUS_IACK; // R08
							size_next = `CIA_SIZE_BYTE; // R08
							kind_next = cia_pkg::cia_ack_full;
							st_next   = cia_st_full;
						end
					end
				end
			end
			cia_st_full: begin
				if (!link.fault_n) begin // R10
					strobe_next = 1'h0;
					av_next     = 1'h0;
					flt_next    = 1'h1;
					done_next   = 1'h1;
					cnt_next    = `CIA_HOLDOFF;
					st_next     = cia_st_idle;
				end else if (!link.retry_n) begin // R10
					strobe_next = 1'h0;
					st_next     = cia_st_retry;
				end else if (!link.async_transfer_ack_n) begin
					vec_next    = link.vector_data; // R07 R09
					data_latched_out_n_next = 1'h0;
					strobe_next = 1'h0;
					av_next     = 1'h0;
					done_next   = 1'h1; // R23
					cnt_next    = `CIA_HOLDOFF;
					st_next     = cia_st_idle;
				end
			end
			cia_st_retry: begin
				// same address and status kept so the redo is identical
				if (link.retry_n) begin
					strobe_next = 1'h1;
					st_next     = cia_st_full;
				end
			end
			cia_st_fixed: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h1) begin // R14 R19
					strobe_next = 1'h0;
					av_next     = 1'h0;
					done_next   = 1'h1;
					cnt_next    = `CIA_HOLDOFF;
					st_next     = cia_st_idle;
				end
			end
			default: begin
				st_next = cia_st_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg     <= cia_st_idle;
			cnt_reg    <= 3'h0;
			addr_reg   <= '0;
			av_reg     <= 1'h0;
			strobe_reg <= 1'h0;
			sas_reg    <= `CIA_STATUS_IACK;
			size_reg   <= `CIA_SIZE_BYTE;
			data_latched_out_n_reg <= 1'h1;
			done_reg   <= 1'h0;
			flt_reg    <= 1'h0;
			vec_reg    <= 8'h00;
			kind_reg   <= cia_pkg::cia_ack_none;
			pend_reg   <= 1'h0;
			abort_reg  <= 1'h0;
		end else if (clk_en) begin
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			addr_reg   <= addr_next;
			av_reg     <= av_next;
			strobe_reg <= strobe_next;
			sas_reg    <= sas_next;
			size_reg   <= size_next;
			data_latched_out_n_reg <= data_latched_out_n_next; // R14
			done_reg   <= done_next;
			flt_reg    <= flt_next;
			vec_reg    <= vec_next;
			kind_reg   <= kind_next;
			pend_reg   <= pend_next;
			abort_reg  <= abort_next;
		end
	end

	assign link.ack_addr             = addr_reg;
	assign link.addr_valid           = av_reg;
	assign link.access_status_code   = sas_reg;
	assign link.transfer_size        = size_reg;
	assign link.ack_strobe           = strobe_reg;
	assign link.data_latched_out_n   = data_latched_out_n_reg;
	assign intr_pending = pend_reg;
	assign abort_instr  = abort_reg;
	assign ack_done     = done_reg;
	assign ack_faulted  = flt_reg;
	assign vector_out   = vec_reg; // R23
	assign ack_kind     = kind_reg; // R23
endmodule

// [core/cia_requester.sv]
// interrupting party: raises requests and answers the acknowledge
// assumes the link interface on one side, a local user port on the other
`timescale 1ns/1ps
`include "cia_defs.svh"
module cia_requester (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	cia_if.requester        link,
	input  wire logic       req_valid,
	input  wire logic [3:0] req_level,
	input  wire logic       req_option_n,
	input  wire logic       req_auto,
	input  wire logic       req_nmi,
	input  wire logic [7:0] req_vector,
	output logic            req_busy,
	output logic            req_served
);
	typedef enum logic [1:0] {
		cia_rq_idle,
		cia_rq_wait,
		cia_rq_answer
	} cia_rq_state_type;

	cia_rq_state_type st_reg, st_next;
	logic [3:0] lvl_reg, lvl_next;
	logic       opt_reg, opt_next, av_n_reg, av_n_next, nmi_n_reg, nmi_n_next;
	logic       auto_reg, auto_next, async_transfer_ack_n_reg, async_transfer_ack_n_next;
	logic [7:0] vec_reg, vec_next;
	logic       busy_reg, busy_next, served_reg, served_next;

	always_comb begin
		st_next      = st_reg;
		lvl_next     = lvl_reg;
		opt_next     = opt_reg;
		av_n_next    = av_n_reg;
		nmi_n_next   = nmi_n_reg;
		auto_next    = auto_reg;
		async_transfer_ack_n_next = 1'h1;
		vec_next     = vec_reg;
		busy_next    = busy_reg;
		served_next  = 1'h0;
		case (st_reg)
			cia_rq_idle: begin
				if (req_valid) begin
					busy_next  = 1'h1;
					nmi_n_next = ~req_nmi;
					lvl_next   = req_nmi ? `CIA_NONE_CODE : req_level;
					opt_next   = req_option_n;
					vec_next   = req_vector;
					auto_next  = req_auto && !req_nmi;
					st_next    = cia_rq_wait;
				end
			end
			cia_rq_wait: begin
				av_n_next = ~auto_reg; // R17
				if (link.ack_strobe) begin
					if (link.access_status_code == `CIA_STATUS_IACK) begin
						async_transfer_ack_n_next = 1'h0; // R09
						st_next      = cia_rq_answer;
					end else begin
						lvl_next    = `CIA_NONE_CODE; // R15
						av_n_next   = 1'h1; // R15
						nmi_n_next  = 1'h1; // R21
						busy_next   = 1'h0;
						served_next = 1'h1;
						st_next     = cia_rq_idle;
					end
				end
			end
			cia_rq_answer: begin
				lvl_next    = `CIA_NONE_CODE; // R11
				busy_next   = 1'h0;
				served_next = 1'h1;
				st_next     = cia_rq_idle;
			end
			default: begin
				st_next = cia_rq_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg      <= cia_rq_idle;
			lvl_reg     <= `CIA_NONE_CODE;
			opt_reg     <= 1'h1;
			av_n_reg    <= 1'h1;
			nmi_n_reg   <= 1'h1;
			auto_reg    <= 1'h0;
			async_transfer_ack_n_reg <= 1'h1;
			vec_reg     <= 8'h00;
			busy_reg    <= 1'h0;
			served_reg  <= 1'h0;
		end else if (clk_en) begin
			st_reg      <= st_next;
			lvl_reg     <= lvl_next;
			opt_reg     <= opt_next;
			av_n_reg    <= av_n_next;
			nmi_n_reg   <= nmi_n_next;
			auto_reg    <= auto_next;
			async_transfer_ack_n_reg <= async_transfer_ack_n_next;
			vec_reg     <= vec_next;
			busy_reg    <= busy_next;
			served_reg  <= served_next;
		end
	end

	assign link.level_request_inputs   = lvl_reg;
	assign link.request_option_input_n = opt_reg;
	assign link.self_vector_request_n  = av_n_reg;
	assign link.nonmaskable_request_n  = nmi_n_reg;
	assign link.vector_data            = vec_reg; // R09
	assign link.async_transfer_ack_n   = async_transfer_ack_n_reg; // R09
	assign link.fault_n                = 1'h1;
	assign link.retry_n                = 1'h1;
	assign req_busy   = busy_reg;
	assign req_served = served_reg;
endmodule

// [dv/cia_props.sv]
// checker for the signals of the acknowledge link
// assumes instantiation beside the link interface, one clock, sync reset
`timescale 1ns/1ps
`include "cia_defs.svh"
module cia_props (
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire logic [`CIA_LVL_W-1:0]  level_request_inputs,
	input wire logic                   request_option_input_n,
	input wire logic                   async_transfer_ack_n,
	input wire logic                   fault_n,
	input wire logic                   retry_n,
	input wire logic [`CIA_ADDR_W-1:0] ack_addr,
	input wire logic [3:0]             access_status_code,
	input wire logic [1:0]             transfer_size,
	input wire logic                   ack_strobe,
	input wire logic                   data_latched_out_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	property p_nmi_addr;
		$rose(ack_strobe) && !ack_addr[0] |-> ack_addr == 32'h0 && access_status_code == `CIA_STATUS_AVACK;
	endproperty
	a_nmi_addr: assert property (p_nmi_addr) else $error("nonmaskable ack address not zero");
	property p_lvl_addr;
		$rose(ack_strobe) && ack_addr[0] |-> ack_addr[31:7] == 25'h0 && ack_addr[1]
			&& ack_addr[6] == !$past(request_option_input_n) && ack_addr[5:2] == ~$past(level_request_inputs);
	endproperty
	a_lvl_addr: assert property (p_lvl_addr) else $error("ack address does not carry inverted level");
	property p_full_size;
		$rose(ack_strobe) && access_status_code == `CIA_STATUS_IACK |-> transfer_size == `CIA_SIZE_BYTE;
	endproperty
	a_full_size: assert property (p_full_size) else $error("full ack not a byte read");
	property p_auto_len;
		$rose(ack_strobe) && access_status_code == `CIA_STATUS_AVACK |-> ack_strobe[*3] ##1 !ack_strobe;
	endproperty
	a_auto_len: assert property (p_auto_len) else $error("auto ack length wrong");
	property p_auto_data_latched_out;
		ack_strobe && access_status_code == `CIA_STATUS_AVACK |=> data_latched_out_n;
	endproperty
	a_auto_data_latched_out: assert property (p_auto_data_latched_out) else $error("data latched flag in auto ack");
	property p_full_wait;
		ack_strobe && access_status_code == `CIA_STATUS_IACK && async_transfer_ack_n && fault_n && retry_n
			&& $past(async_transfer_ack_n) && $past(fault_n) && $past(retry_n) |=> ack_strobe;
	endproperty
	a_full_wait: assert property (p_full_wait) else $error("full ack ended without acknowledge");
	property p_full_end;
		ack_strobe && access_status_code == `CIA_STATUS_IACK && !async_transfer_ack_n && fault_n && retry_n
			|-> ##[1:2] (!ack_strobe && !data_latched_out_n);
	endproperty
	a_full_end: assert property (p_full_end) else $error("full ack did not end with data latched");
	property p_addr_hold;
		ack_strobe && $past(ack_strobe) |-> $stable(ack_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("ack address moved during ack");
endmodule

// [dv/cpu_interrupt_acknowledge_tb.sv]
// bench: device and requester joined by one link, a second device driven by the bench
// assumes the cia design files and headers are compiled before it
`timescale 1ns/1ps
`include "cia_defs.svh"
module cpu_interrupt_acknowledge_tb;
	logic                 core_clk, rst, boundary, abortable, req_valid, req_option_n, req_auto, req_nmi;
	logic [3:0]           mask, req_level;
	logic [7:0]           req_vector, vector_out;
	logic                 done, done2, faulted2;
	cia_pkg::cia_ack_type ack_kind;
	int                   bad_count, checked;
	cia_if link();
	cia_if link2();
	cia_device cia_device_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .link(link),
		.priority_mask_field(mask), .instr_boundary(boundary), .instr_abortable(abortable),
		.intr_pending(), .abort_instr(), .ack_done(done), .ack_faulted(), .vector_out(vector_out),
		.ack_kind(ack_kind));
	// second device faces the bench so faults can be injected
	cia_device cia_device_i2 (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .link(link2),
		.priority_mask_field(mask), .instr_boundary(boundary), .instr_abortable(abortable),
		.intr_pending(), .abort_instr(), .ack_done(done2), .ack_faulted(faulted2), .vector_out(),
		.ack_kind());
	cia_requester cia_requester_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .link(link),
		.req_valid(req_valid), .req_level(req_level), .req_option_n(req_option_n), .req_auto(req_auto),
		.req_nmi(req_nmi), .req_vector(req_vector), .req_busy(), .req_served());
	cia_props cia_props_i (.core_clk(core_clk), .rst(rst), .level_request_inputs(link.level_request_inputs),
		.request_option_input_n(link.request_option_input_n), .async_transfer_ack_n(link.async_transfer_ack_n),
		.fault_n(link.fault_n), .retry_n(link.retry_n), .ack_addr(link.ack_addr),
		.access_status_code(link.access_status_code), .transfer_size(link.transfer_size),
		.ack_strobe(link.ack_strobe), .data_latched_out_n(link.data_latched_out_n));
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_kind(input cia_pkg::cia_ack_type got, input cia_pkg::cia_ack_type exp);
		chk_val({30'h0, got}, {30'h0, exp});
	endtask
	// a bound that runs out while an ack is due ends the run
	task automatic wait_done(input logic which, input int n, input logic want);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(negedge core_clk);
			seen = (which ? done2 : done) === 1'b1;
		end
		chk_val({31'h0, seen}, {31'h0, want});
		if (want && !seen) results();
	endtask
	task automatic send(input logic [3:0] lvl, input logic opt_n, input logic au, input logic nm,
		input logic [7:0] vec);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_level <= lvl;
		req_option_n <= opt_n;
		req_auto <= au;
		req_nmi <= nm;
		req_vector <= vec;
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	task automatic expect_ack(input logic [3:0] lvl, input logic opt_n, input logic au, input logic nm,
		input logic [7:0] vec);
		logic [7:0]           ev;
		logic [31:0]          ea;
		cia_pkg::cia_ack_type ek;
		wait_done(1'b0, 40, 1'b1);
		ev = nm ? `CIA_NMI_VECTOR : (au ? {3'h0, ~opt_n, lvl} : vec);
		ea = nm ? 32'h0 : {25'h0, ~opt_n, ~lvl, 2'h3};
		ek = nm ? cia_pkg::cia_ack_nmi : (au ? cia_pkg::cia_ack_auto : cia_pkg::cia_ack_full);
		chk_val({24'h0, vector_out}, {24'h0, ev});
		chk_val(link.ack_addr, ea);
		chk_val({28'h0, link.access_status_code},
			{28'h0, (nm | au) ? `CIA_STATUS_AVACK : `CIA_STATUS_IACK});
		chk_kind(ack_kind, ek);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic ack(input logic [3:0] lvl, input logic opt_n, input logic au, input logic nm,
		input logic [7:0] vec);
		send(lvl, opt_n, au, nm, vec);
		expect_ack(lvl, opt_n, au, nm, vec);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		{mask, boundary, abortable, req_valid, req_level, req_option_n} = {4'h0, 3'h4, 4'hf, 1'b1};
		{req_auto, req_nmi, req_vector, bad_count, checked} = '0;
		{link2.level_request_inputs, link2.request_option_input_n, link2.self_vector_request_n} = 6'h3f;
		{link2.nonmaskable_request_n, link2.vector_data, link2.async_transfer_ack_n} = 10'h2ff;
		{link2.fault_n, link2.retry_n} = 2'h3;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		for (int l = 0; l < 15; l++) ack(l[3:0], l[0], 1'b0, 1'b0, 8'h40 + l[7:0]);
		$display("test full done");
		for (int l = 0; l < 15; l++) ack(l[3:0], ~l[1], 1'b1, 1'b0, 8'h00);
		$display("test auto done");
		@(posedge core_clk);
		mask <= 4'hf;
		ack(4'h7, 1'b1, 1'b0, 1'b1, 8'h99);
		$display("test nmi done");
		@(posedge core_clk);
		mask <= 4'h5;
		send(4'ha, 1'b1, 1'b0, 1'b0, 8'h21);
		wait_done(1'b0, 30, 1'b0);
		@(posedge core_clk);
		mask <= 4'h4;
		expect_ack(4'ha, 1'b1, 1'b0, 1'b0, 8'h21);
		$display("test mask done");
		// not at a boundary: ack waits until the instruction is abortable
		@(posedge core_clk);
		mask <= 4'h0;
		boundary <= 1'b0;
		send(4'h3, 1'b0, 1'b0, 1'b0, 8'h5a);
		wait_done(1'b0, 30, 1'b0);
		@(posedge core_clk);
		abortable <= 1'b1;
		expect_ack(4'h3, 1'b0, 1'b0, 1'b0, 8'h5a);
		abortable <= 1'b0;
		boundary <= 1'b1;
		$display("test boundary done");
		// one-cycle glitch on the level pins must not be taken
		@(posedge core_clk);
		link2.level_request_inputs <= 4'h2;
		@(posedge core_clk);
		link2.level_request_inputs <= 4'hf;
		wait_done(1'b1, 20, 1'b0);
		@(posedge core_clk);
		link2.level_request_inputs <= 4'h3;
		link2.fault_n <= 1'b0;
		wait_done(1'b1, 30, 1'b1);
		chk_val({31'h0, faulted2}, 32'h1);
		@(posedge core_clk);
		link2.level_request_inputs <= 4'hf;
		link2.fault_n <= 1'b1;
		$display("test fault done");
		results();
	end
endmodule
